// ---- hw/psucm_rom.sv ----
// Purpose: 256x8 identification data store
// Assumes: one write port, registered read
// Notes:   contents loaded by the production write path, not initialised at power-up
`timescale 1ns/10ps
module psucm_rom (
  // clock
  input  wire logic       clk_i,
  // write
  input  wire logic       we_i,
  input  wire logic [7:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  // read
  input  wire logic [7:0] raddr_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem_r [0:255];
  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem_r[waddr_i] <= wdata_i;
    rdata_o <= mem_r[raddr_i];
  end
endmodule

// ---- hw/psucm_tick.sv ----
// Purpose: free-running 1 ms timebase
// Assumes: 125 MHz clock
// Notes:   one-cycle pulse every millisecond
`timescale 1ns/10ps
`include "psucm_regs.svh"
module psucm_tick #(
  parameter int TICK_CYC = `PSUCM_TICK_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // tick
  output logic      tick_o
);
  localparam logic [16:0] LAST = 17'(TICK_CYC - 1);
  logic [16:0] cnt_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= 17'h00000;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt_r == LAST);
      cnt_r  <= (cnt_r == LAST) ? 17'h00000 : cnt_r + 17'h00001;
    end
  end
endmodule

// ---- hw/psucm_top.sv ----
// Purpose: power-on sequencing, power good, input ok and management serial target
// Assumes: pins and analog monitor flags arrive synchronous-capable; one 125 MHz clock
// Notes:   serial target is read-mostly: the first byte written after the address sets the store pointer
`timescale 1ns/10ps
`include "psucm_regs.svh"
module psucm_top #(
  // cycles per millisecond tick; a bench may shorten it to keep runs short
  parameter int TICK_CYC = `PSUCM_TICK_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // host control pins
  input  wire logic       power_on_request_n_i,
  output logic            main_enable_o,
  output logic            standby_enable_o,
  output logic            power_good_o,
  output logic            vin_good_o,
  output logic            module_n_a_o,
  // analog monitor flags
  input  wire logic       in_regulation_i,
  input  wire logic       current_limit_i,
  input  wire logic       vin_in_range_i,
  input  wire logic       vin_module_n_a_i,
  input  wire logic       over_voltage_shutdown_i,
  input  wire logic       short_circuit_shutdown_i,
  // management serial pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            scl_o,
  output logic            scl_oe_o,
  // store load port
  input  wire logic       id_we_i,
  input  wire logic [7:0] id_waddr_i,
  input  wire logic [7:0] id_wdata_i
);
  //////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] req_s_r, reg_s_r, cl_s_r, rng_s_r, pres_s_r, ovp_s_r, scp_s_r, scl_s_r, sda_s_r;
  logic       scl_d_r, sda_d_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_s_r  <= 2'h3;
      reg_s_r  <= 2'h0;
      cl_s_r   <= 2'h0;
      rng_s_r  <= 2'h0;
      pres_s_r <= 2'h0;
      ovp_s_r  <= 2'h0;
      scp_s_r  <= 2'h0;
      scl_s_r  <= 2'h3;
      sda_s_r  <= 2'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end
    else
    begin
      req_s_r  <= {req_s_r[0], power_on_request_n_i};
      reg_s_r  <= {reg_s_r[0], in_regulation_i};
      cl_s_r   <= {cl_s_r[0], current_limit_i};
      rng_s_r  <= {rng_s_r[0], vin_in_range_i};
      pres_s_r <= {pres_s_r[0], vin_module_n_a_i};
      ovp_s_r  <= {ovp_s_r[0], over_voltage_shutdown_i};
      scp_s_r  <= {scp_s_r[0], short_circuit_shutdown_i};
      scl_s_r  <= {scl_s_r[0], scl_i};
      sda_s_r  <= {sda_s_r[0], sda_i};
      scl_d_r  <= scl_s_r[1];
      sda_d_r  <= sda_s_r[1];
    end
  end
  wire req_on    = ~req_s_r[1];
  wire outs_ok   = reg_s_r[1];
  wire cur_lim   = cl_s_r[1];
  wire vin_ok    = rng_s_r[1] & pres_s_r[1];
  wire fault     = ovp_s_r[1] | scp_s_r[1];
  wire tick;
  psucm_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );
  //////////////////////////////////////////////////////////////////////////////
  // power sequencing
  psucm_pkg::psucm_seq_t seq_r, seq_nxt;
  logic [8:0] ms_r;
  logic [3:0] loss_r;
  wire        vin_lost  = (loss_r >= 4'(`PSUCM_VIN_LOSS_MS));
  wire        up_done   = (ms_r >= 9'(`PSUCM_UP_MS - 1)) & tick;
  always_comb
  begin
    seq_nxt = seq_r;
    unique case (seq_r)
      psucm_pkg::SEQ_OFF:     if (req_on & vin_ok) seq_nxt = psucm_pkg::SEQ_DELAY;
      psucm_pkg::SEQ_DELAY:   if (!req_on) seq_nxt = psucm_pkg::SEQ_OFF;
                              else if (up_done) seq_nxt = psucm_pkg::SEQ_ON;
      psucm_pkg::SEQ_ON:      if (!req_on) seq_nxt = psucm_pkg::SEQ_OFF;
                              else if (fault) seq_nxt = psucm_pkg::SEQ_LATCHED;
                              else if (vin_lost) seq_nxt = psucm_pkg::SEQ_OFF;
      psucm_pkg::SEQ_LATCHED: if (!req_on || vin_lost) seq_nxt = psucm_pkg::SEQ_OFF;
      default:                seq_nxt = psucm_pkg::SEQ_OFF;
    endcase
  end
  // power good delay runs only while in regulation and out of current limit
  logic [8:0] good_ms_r;
  wire        good_run  = (seq_r == psucm_pkg::SEQ_ON) & outs_ok & req_on;
  wire        good_hit  = (good_ms_r >= 9'(`PSUCM_GOOD_MS));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_r        <= psucm_pkg::SEQ_OFF;
      ms_r         <= 9'h000;
      good_ms_r    <= 9'h000;
      loss_r       <= 4'h0;
      power_good_o <= 1'b0;
      vin_good_o   <= 1'b0;
    end
    else
    begin
      seq_r <= seq_nxt;
      if (seq_r != psucm_pkg::SEQ_DELAY)
        ms_r <= 9'h000;
      else if (tick)
        ms_r <= ms_r + 9'h001;
      if (!good_run)
        good_ms_r <= 9'h000;
      else if (tick && !cur_lim && !good_hit)
        good_ms_r <= good_ms_r + 9'h001;
      power_good_o <= good_run & good_hit & ~vin_lost;
      if (vin_ok)
        loss_r <= 4'h0;
      else if (tick && !vin_lost)
        loss_r <= loss_r + 4'h1;
      vin_good_o <= vin_ok;
    end
  end
  assign main_enable_o    = (seq_r == psucm_pkg::SEQ_ON);
  assign standby_enable_o = 1'b1;
  assign module_n_a_o     = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // management serial target; never stretches the clock
  assign scl_o    = 1'b0;
  assign scl_oe_o = 1'b0;
  wire scl    = scl_s_r[1];
  wire sda    = sda_s_r[1];
  wire scl_re = scl & ~scl_d_r;
  wire scl_fe = ~scl & scl_d_r;
  wire start  = scl & scl_d_r & sda_d_r & ~sda;
  wire stop   = scl & scl_d_r & ~sda_d_r & sda;
  psucm_pkg::psucm_i2c_t i2c_r;
  logic [7:0] sh_r, ptr_r, rdat;
  logic [2:0] bit_r;
  logic       rw_r, first_r, nack_r, drv_r, byte_r;
  logic [4:0] low_r;
  logic [3:0] quiet_r;
  wire        tout   = (low_r >= 5'(`PSUCM_TLOW_MS));
  wire        qdone  = (quiet_r >= 4'(`PSUCM_QUIET_MS));
  wire        addr_hit = (sh_r[7:1] == `PSUCM_SLAVE_ADDR);
  psucm_rom u_rom (
    .clk_i   (clk_i),
    .we_i    (id_we_i),
    .waddr_i (id_waddr_i),
    .wdata_i (id_wdata_i),
    .raddr_i (ptr_r),
    .rdata_o (rdat)
  );
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      i2c_r   <= psucm_pkg::I2C_IDLE;
      sh_r    <= 8'h00;
      ptr_r   <= 8'h00;
      bit_r   <= 3'h0;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
      nack_r  <= 1'b0;
      drv_r   <= 1'b0;
      byte_r  <= 1'b0;
      low_r   <= 5'h00;
      quiet_r <= 4'h0;
    end
    else
    begin
      if (scl || i2c_r == psucm_pkg::I2C_IDLE || i2c_r == psucm_pkg::I2C_QUIET)
        low_r <= 5'h00;
      else if (tick && !tout)
        low_r <= low_r + 5'h01;
      if (i2c_r != psucm_pkg::I2C_QUIET)
        quiet_r <= 4'h0;
      else if (tick && !qdone)
        quiet_r <= quiet_r + 4'h1;
      if (tout && i2c_r != psucm_pkg::I2C_QUIET)
      begin
        i2c_r <= psucm_pkg::I2C_QUIET;
        drv_r <= 1'b0;
      end
      else if (i2c_r == psucm_pkg::I2C_QUIET)
      begin
        if (qdone)
          i2c_r <= psucm_pkg::I2C_IDLE;
      end
      else if (stop)
      begin
        i2c_r <= psucm_pkg::I2C_IDLE;
        drv_r <= 1'b0;
      end
      else if (start)
      begin
        i2c_r  <= psucm_pkg::I2C_ADDR;
        bit_r  <= 3'h0;
        drv_r  <= 1'b0;
        byte_r <= 1'b0;
      end
      else
      begin
        unique case (i2c_r)
          psucm_pkg::I2C_IDLE, psucm_pkg::I2C_SKIP:
            drv_r <= 1'b0;
          psucm_pkg::I2C_ADDR, psucm_pkg::I2C_WRX:
            if (scl_re)
            begin
              sh_r   <= {sh_r[6:0], sda};
              bit_r  <= bit_r + 3'h1;
              byte_r <= (bit_r == 3'h7);
            end
            // the clock fall that ends a start must not look like a full byte
            else if (scl_fe && byte_r)
            begin
              byte_r <= 1'b0;
              if (i2c_r == psucm_pkg::I2C_WRX)
              begin
                ptr_r   <= first_r ? sh_r : ptr_r;
                first_r <= 1'b0;
                drv_r   <= 1'b1;
                i2c_r   <= psucm_pkg::I2C_ACK;
              end
              else if (addr_hit)
              begin
                rw_r    <= sh_r[0] ? 1'b1 : 1'b0;
                first_r <= 1'b1;
                drv_r   <= 1'b1;
                i2c_r   <= psucm_pkg::I2C_ACK;
              end
              else
                i2c_r <= psucm_pkg::I2C_SKIP;
            end
          psucm_pkg::I2C_ACK:
            if (scl_fe)
            begin
              if (rw_r)
              begin
                sh_r  <= rdat;
                drv_r <= ~rdat[7];
                ptr_r <= ptr_r + 8'h01;
                bit_r <= 3'h1;
                i2c_r <= psucm_pkg::I2C_RDX;
              end
              else
              begin
                drv_r <= 1'b0;
                bit_r <= 3'h0;
                i2c_r <= psucm_pkg::I2C_WRX;
              end
            end
          psucm_pkg::I2C_RDX:
            if (scl_fe)
            begin
              if (bit_r == 3'h0)
              begin
                drv_r <= 1'b0;
                i2c_r <= psucm_pkg::I2C_RACK;
              end
              else
              begin
                drv_r <= ~sh_r[3'h7 - bit_r];
                bit_r <= bit_r + 3'h1;
              end
            end
          psucm_pkg::I2C_RACK:
            if (scl_re)
              nack_r <= sda;
            else if (scl_fe)
            begin
              if (nack_r)
                i2c_r <= psucm_pkg::I2C_SKIP;
              else
              begin
                sh_r  <= rdat;
                drv_r <= ~rdat[7];
                ptr_r <= ptr_r + 8'h01;
                bit_r <= 3'h1;
                i2c_r <= psucm_pkg::I2C_RDX;
              end
            end
          default:
            i2c_r <= psucm_pkg::I2C_IDLE;
        endcase
      end
    end
  end
  assign sda_o    = 1'b0;
  assign sda_oe_o = drv_r;
endmodule

// ---- pkg/psucm_pkg.sv ----
// Purpose: types for the supply control and management block
// Assumes: nothing
// Notes:   states only; numbers live in the header
package psucm_pkg;
  typedef enum logic [2:0] {SEQ_OFF, SEQ_DELAY, SEQ_ON, SEQ_LATCHED} psucm_seq_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WRX, I2C_RDX, I2C_RACK,
                            I2C_SKIP, I2C_QUIET} psucm_i2c_t;
endpackage

// ---- pkg/psucm_regs.svh ----
// Purpose: timing constants for the supply control and management block
// Assumes: 125 MHz clock, 1 ms timebase tick
// Notes:   counts in ms ticks; least times round up, longest round down
//
// Overview of operation
// - host drives request low; main output enabled only while it stays low
// - request high or open switches off everything except standby rail; input ok still follows the input regardless of request
// - main output off within 5 ms after request withdrawn
// - main output up between 5 ms and 400 ms after request asserted
// - power good drops within 5 ms after request withdrawn
// - power good high only when every output is in regulation
// - power good low on output out of regulation or input lost too long
// - power good 100 to 500 ms after regulation; count held during current limit
// - input ok high while input module_n_a and in range, low otherwise
// - input ok falls within 2 ms on dropout or brown-out
// - input ok low no later than 4 ms after input reaches zero
// - presence pin held at ground; host pulls up and reads low as installed
// - serial target runs at 100 kbps and avoids clock stretching
// - total clock stretch per message stays under 25 ms
// - clock low over 25 ms aborts and releases; new transfers 10 ms later
// - start and stop recognised anywhere within a clock interval
// - never locks up on glitches; resumes once timing is compliant
// - after a missed clock, resynchronise at next start or stop
// - 256 by 8 identification store readable over the serial interface
// - management logic powered whenever any supply has input power
// - latched shutdown cleared only by request cycling or input removal
`ifndef PSUCM_REGS_SVH
`define PSUCM_REGS_SVH
`define PSUCM_CLK_HZ        125000000
`define PSUCM_TICK_CYC      (`PSUCM_CLK_HZ / 1000)
`define PSUCM_OFF_MAX_MS    5
`define PSUCM_UP_MIN_MS     5
`define PSUCM_UP_MAX_MS     400
`define PSUCM_UP_MS         10
`define PSUCM_GOOD_MIN_MS   100
`define PSUCM_GOOD_MAX_MS   500
`define PSUCM_GOOD_MS       150
`define PSUCM_VIN_FALL_MS   2
`define PSUCM_VIN_LOSS_MS   1
`define PSUCM_TLOW_MS       25
`define PSUCM_QUIET_MS      10
`define PSUCM_SLAVE_ADDR    7'h50
`define PSUCM_ROM_DEPTH     256
`endif

// ---- testbench/psucm_chk.sv ----
// Purpose: port checks for the supply control block
// Assumes: one clock, synchronous active-high reset
// Notes:   millisecond windows use saturating counters, not repetition
`timescale 1ns/10ps
`include "psucm_regs.svh"
module psucm_chk #(
  parameter int TICK = `PSUCM_TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host pins
  input wire logic power_on_request_n_i,
  input wire logic main_enable_o,
  input wire logic standby_enable_o,
  input wire logic power_good_o,
  input wire logic vin_good_o,
  input wire logic module_n_a_o,
  // monitor flags
  input wire logic in_regulation_i,
  input wire logic current_limit_i,
  input wire logic vin_in_range_i,
  input wire logic vin_module_n_a_i,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic scl_oe_o
);
  logic [23:0] req_cnt_r;
  logic [23:0] reg_cnt_r;
  logic [23:0] low_cnt_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // counters saturate so that long runs never wrap into a false pass
  always_ff @(posedge clk_i)
  begin
    req_cnt_r <= (rst_i || power_on_request_n_i) ? '0 : req_cnt_r + {23'h0, ~&req_cnt_r};
    reg_cnt_r <= (rst_i || !in_regulation_i) ? '0 :
                 reg_cnt_r + {23'h0, ~&reg_cnt_r && !current_limit_i};
    low_cnt_r <= (rst_i || scl_i) ? '0 : low_cnt_r + {23'h0, ~&low_cnt_r};
  end
  ////////////////////////////////////////////////////////////////
  a_standby_on: assert property (standby_enable_o)
    else $error("standby rail switched off");
  a_presence_gnd: assert property (!module_n_a_o)
    else $error("presence pin not low");
  a_never_stretch: assert property (!scl_oe_o)
    else $error("serial clock stretched");
  a_off_on_release: assert property (power_on_request_n_i [*5] |-> !main_enable_o && !power_good_o)
    else $error("output or good still on after request release");
  a_up_not_early: assert property ($rose(main_enable_o) |-> req_cnt_r >= 24'(5 * TICK))
    else $error("main output rose too early");
  a_good_regulated: assert property ($rose(power_good_o) |-> main_enable_o && in_regulation_i)
    else $error("good rose while output not regulated");
  a_good_drop: assert property (!in_regulation_i [*5] |-> !power_good_o)
    else $error("good held through regulation loss");
  a_good_not_early: assert property ($rose(power_good_o) |-> reg_cnt_r >= 24'(100 * TICK))
    else $error("good rose before its delay");
  a_vin_drop: assert property (!vin_module_n_a_i [*5] |-> !vin_good_o)
    else $error("input ok held after input loss");
  a_vin_rise: assert property ($rose(vin_good_o) |-> $past(vin_module_n_a_i && vin_in_range_i, 3))
    else $error("input ok rose without input");
  a_bus_release: assert property (low_cnt_r > 24'(25 * TICK + 16) |-> !sda_oe_o)
    else $error("data line held after clock low timeout");
  c_main_up: cover property ($rose(main_enable_o));
  c_good_up: cover property ($rose(power_good_o));
  c_vin_fall: cover property ($fell(vin_good_o));
  c_ack: cover property ($rose(sda_oe_o));
endmodule

// ---- testbench/psucm_host_model.sv ----
// Purpose: host board model: request pin and serial bus controller
// Assumes: open-drain lines with pull-ups outside this model
// Notes:   scl and sda outputs are pull-low enables; released means high level
`timescale 1ns/10ps
module psucm_host_model (
  // clock
  input  wire logic clk_i,
  // bus sense
  input  wire logic sda_i,
  // pin drives
  output logic      power_on_request_n_o,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  // bit phase scaled down with the bench timebase, well above the 4-cycle floor
  localparam int QTR = 16;
  initial
  begin
    power_on_request_n_o = 1'b1;
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic ph(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // released request reads high, as the pull-up would leave it
  task automatic request(input logic on);
    power_on_request_n_o = !on;
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    ph(QTR);
    scl_low_o = 1'b0;
    ph(QTR);
    sda_low_o = 1'b1;
    ph(QTR);
    scl_low_o = 1'b1;
    ph(8);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    ph(QTR);
    scl_low_o = 1'b0;
    ph(QTR);
    sda_low_o = 1'b0;
    ph(QTR);
  endtask
  // nine bits: eight data and the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_low_o = !tx[i];
      ph(QTR);
      scl_low_o = 1'b0;
      ph(QTR);
      rx[i] = sda_i;
      scl_low_o = 1'b1;
      ph(8);
    end
  endtask
  // runt clock pulse of one cycle
  task automatic glitch();
    scl_low_o = 1'b0;
    ph(1);
    scl_low_o = 1'b1;
    ph(QTR);
  endtask
endmodule

// ---- testbench/psucm_top_test.sv ----
// Purpose: self-checking bench for the supply control block
// Assumes: the millisecond tick is shortened to TICK cycles to keep the run short
// Notes:   store contents are address xor 5A
`timescale 1ns/10ps
`include "psucm_regs.svh"
module psucm_top_test;
  localparam int TICK = 100;
  localparam int LIMIT = 80000;
  logic clk_i, rst_i, in_reg, cur_lim, vin_rng, vin_pre, ov, sc, we;
  logic [7:0] wa, wd;
  logic [8:0] r;
  wire logic req_n, h_scl_low, h_sda_low, scl, sda, main_en, stby, good, vin_ok, pres;
  wire logic sda_o, sda_oe, scl_o, scl_oe;
  wire logic [3:0] mon;
  int err_total, total_checks, cyc, n;
  assign scl = !(h_scl_low || (scl_oe && !scl_o));
  assign sda = !(h_sda_low || (sda_oe && !sda_o));
  assign mon = {main_en, good, vin_ok, sda_oe};
  psucm_top #(.TICK_CYC(TICK)) dut (.clk_i(clk_i), .rst_i(rst_i), .power_on_request_n_i(req_n),
    .main_enable_o(main_en), .standby_enable_o(stby), .power_good_o(good),
    .vin_good_o(vin_ok), .module_n_a_o(pres), .in_regulation_i(in_reg),
    .current_limit_i(cur_lim), .vin_in_range_i(vin_rng), .vin_module_n_a_i(vin_pre),
    .over_voltage_shutdown_i(ov), .short_circuit_shutdown_i(sc), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .id_we_i(we), .id_waddr_i(wa), .id_wdata_i(wd));
  psucm_host_model host (.clk_i(clk_i), .sda_i(sda), .power_on_request_n_o(req_n),
    .scl_low_o(h_scl_low), .sda_low_o(h_sda_low));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi)
    begin
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, n);
      err_total++;
    end
  endtask
  // mon bits: 3 main, 2 good, 1 input ok, 0 data drive
  task automatic wait_for(input int sel, input logic v, input int lim);
    n = 0;
    while (mon[sel] !== v && n < lim)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic rd(input logic [7:0] p);
    host.start();
    host.xfer({8'hA0, 1'b1}, r);
    chk("write address ack", 8'h00, r[0]);
    host.xfer({p, 1'b1}, r);
    host.start();
    host.xfer({8'hA1, 1'b1}, r);
    chk("read address ack", 8'h00, r[0]);
    host.xfer({8'hFF, 1'b0}, r);
    chk("first byte", p ^ 8'h5A, r[8:1]);
    host.xfer({8'hFF, 1'b1}, r);
    chk("second byte", (p + 8'h01) ^ 8'h5A, r[8:1]);
    host.stop();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    step(20);
    chk("main idle", 8'h00, main_en);
    chk("standby", 8'h01, stby);
    chk("presence", 8'h00, pres);
    chk("input ok", 8'h01, vin_ok);
  endtask
  task automatic t_power();
    host.request(1'b1);
    wait_for(3, 1'b1, 401 * TICK);
    chk_rng("up delay", 5 * TICK, 400 * TICK);
    in_reg = 1'b1;
    cur_lim = 1'b1;
    // a count run under current limit would show as a good delay under 100 ms below
    step(55 * TICK);
    chk("good under limit", 8'h00, good);
    cur_lim = 1'b0;
    wait_for(2, 1'b1, 501 * TICK);
    chk_rng("good delay", 100 * TICK, 500 * TICK);
    host.request(1'b0);
    wait_for(2, 1'b0, 5 * TICK + 1);
    chk_rng("good drop", 0, 5 * TICK);
    chk("main off", 8'h00, main_en);
    in_reg = 1'b0;
  endtask
  task automatic t_vin();
    vin_pre = 1'b0;
    vin_rng = 1'b0;
    wait_for(1, 1'b0, 2 * TICK + 1);
    chk_rng("input ok fall", 0, 2 * TICK);
    vin_pre = 1'b1;
    vin_rng = 1'b1;
    wait_for(1, 1'b1, 10);
    chk("input ok back", 8'h01, vin_ok);
  endtask
  task automatic t_latch();
    for (int k = 0; k < 2; k++)
    begin
      host.request(1'b1);
      wait_for(3, 1'b1, 401 * TICK);
      chk("main before fault", 8'h01, main_en);
      ov = (k == 0);
      sc = (k == 1);
      step(4);
      ov = 1'b0;
      sc = 1'b0;
      wait_for(3, 1'b0, 100);
      chk("main after fault", 8'h00, main_en);
      step(12 * TICK);
      chk("main latched", 8'h00, main_en);
      host.request(1'b0);
      step(TICK);
      host.request(1'b1);
      wait_for(3, 1'b1, 401 * TICK);
      chk("main after cycling", 8'h01, main_en);
      host.request(1'b0);
      wait_for(3, 1'b0, 5 * TICK);
    end
  endtask
  task automatic t_store();
    for (int a = 0; a < 256; a++)
    begin
      we = 1'b1;
      wa = 8'(a);
      wd = 8'(a) ^ 8'h5A;
      step(1);
    end
    we = 1'b0;
    rd(8'hFF);
    host.start();
    host.xfer({8'h42, 1'b1}, r);
    chk("foreign address nack", 8'h01, r[0]);
    host.stop();
  endtask
  task automatic t_bus_fault();
    host.start();
    host.xfer({8'hA1, 1'b1}, r);
    chk("data drive before timeout", 8'h01, sda_oe);
    step(26 * TICK);
    chk("bus released", 8'h00, sda_oe);
    step(11 * TICK);
    host.stop();
    rd(8'h10);
    host.start();
    host.xfer({8'hA0, 1'b1}, r);
    repeat (3) host.glitch();
    rd(8'h33);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    in_reg = 1'b0;
    cur_lim = 1'b0;
    ov = 1'b0;
    sc = 1'b0;
    we = 1'b0;
    vin_rng = 1'b1;
    vin_pre = 1'b1;
    wa = 8'h00;
    wd = 8'h00;
    step(4);
    rst_i = 1'b0;
    t_reset();
    t_power();
    t_vin();
    t_latch();
    t_store();
    t_bus_fault();
    conclude();
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      conclude();
    end
  end
endmodule
bind psucm_top psucm_chk #(.TICK(TICK_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .power_on_request_n_i(power_on_request_n_i), .main_enable_o(main_enable_o),
  .standby_enable_o(standby_enable_o), .power_good_o(power_good_o),
  .vin_good_o(vin_good_o), .module_n_a_o(module_n_a_o), .in_regulation_i(in_regulation_i),
  .current_limit_i(current_limit_i), .vin_in_range_i(vin_in_range_i),
  .vin_module_n_a_i(vin_module_n_a_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o), .scl_oe_o(scl_oe_o));
